// ==== src/gpiu_top.v ====
// general purpose interrupt unit with axi4-lite register slave
`timescale 1ns/10ps
`include "gpiu_defs.vh"
// Notes on behaviour
// - four processor sources, one status bit each
// - firmware fatal error raises forced source
// - watchdog timeout without restart raises source
// - any transmit slew error sets one bit
// - calibration or system fault raises system error
// - stream processor faults get dedicated bits
// - memory ecc error sets its bit
// - status bits stick until software clears
// - pins follow live unmasked sources, no latch
// - status records every source since clear
// - per pin mask, one blocks source
// - mask write selects first, second or both
// - pin masks never affect the status word
// - clear resets together all status bits whose source is not live
// - enabled pa events ramp transmit attenuation
// - ramp sticky or auto clearing by setting
module gpiu_top (
    input  wire                    mclk_i,        // 125 mhz clock
    input  wire                    rst_n_i,       // async reset, low
    // axi4-lite slave
    input  wire [7:0]              s_axi_awaddr,  // write address
    input  wire                    s_axi_awvalid, // write addr valid
    output reg                     s_axi_awready, // write addr ready
    input  wire [31:0]             s_axi_wdata,   // write data
    input  wire [3:0]              s_axi_wstrb,   // byte enables
    input  wire                    s_axi_wvalid,  // write data valid
    output reg                     s_axi_wready,  // write data ready
    output reg  [1:0]              s_axi_bresp,   // write response
    output reg                     s_axi_bvalid,  // write resp valid
    input  wire                    s_axi_bready,  // write resp ready
    input  wire [7:0]              s_axi_araddr,  // read address
    input  wire                    s_axi_arvalid, // read addr valid
    output reg                     s_axi_arready, // read addr ready
    output reg  [31:0]             s_axi_rdata,   // read data
    output reg  [1:0]              s_axi_rresp,   // read response
    output reg                     s_axi_rvalid,  // read data valid
    input  wire                    s_axi_rready,  // read data ready
    // source events from the device
    input  wire                    fw_fatal_i,    // firmware fatal error
    input  wire                    wdog_kick_i,   // watchdog restart
    input  wire [`GPIU_NTX-1:0]    slew_err_i,    // per tx slew error
    input  wire                    cal_err_i,     // calibration fault
    input  wire                    sys_err_i,     // system fault
    input  wire [`GPIU_NSTRM-1:0]  strm_err_i,    // stream proc faults
    input  wire                    ecc_err_i,     // memory ecc error
    input  wire [`GPIU_NPA-1:0]    pa_event_i,    // pa protection events
    input  wire [`GPIU_NOTHER-1:0] other_src_i,   // remaining sources
    // outputs
    output reg                     first_irq_pin_o,  // first pin
    output reg                     second_irq_pin_o, // second pin
    output reg                     tx_atten_ramp_o   // attenuation ramp
);
    // synchronised pa events and other sources from pins
    wire [`GPIU_NPA-1:0]    pa_sync;
    wire [`GPIU_NOTHER-1:0] other_sync;
    wire                    wdog_expire;

    genvar gi;
    generate
        for (gi = 0; gi < `GPIU_NPA; gi = gi + 1) begin : g_pa
            gpiu_sync u_sync (
                .mclk_i  (mclk_i),
                .rst_n_i (rst_n_i),
                .d_i     (pa_event_i[gi]),
                .q_o     (pa_sync[gi])
            );
        end
        for (gi = 0; gi < `GPIU_NOTHER; gi = gi + 1) begin : g_oth
            gpiu_sync u_sync (
                .mclk_i  (mclk_i),
                .rst_n_i (rst_n_i),
                .d_i     (other_src_i[gi]),
                .q_o     (other_sync[gi])
            );
        end
    endgenerate

    reg [`GPIU_WDOG_W-1:0] wdog_limit_reg;

    gpiu_wdog u_wdog (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .kick_i   (wdog_kick_i),
        .limit_i  (wdog_limit_reg),
        .expire_o (wdog_expire)
    );

    // live source word
    wire [63:0] live;
    assign live = {other_sync,
                   pa_sync,
                   ecc_err_i,
                   strm_err_i,
                   cal_err_i | sys_err_i,
                   |slew_err_i,
                   wdog_expire,
                   fw_fatal_i};

    reg [63:0] status_reg;
    reg [63:0] first_pin_mask_word_reg;
    reg [63:0] second_pin_mask_word_reg;
    reg [1:0]  interrupt_mask_target_reg;
    reg        pa_en_reg;
    reg        pa_sticky_reg;
    reg        ramp_hold_reg;

    // write channel state
    reg        aw_have_reg;
    reg        w_have_reg;
    reg [7:0]  aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;

    wire       wr_go;
    wire       aw_now;
    wire       w_now;
    wire [7:0] wr_addr;
    assign aw_now  = s_axi_awvalid & s_axi_awready;
    assign w_now   = s_axi_wvalid & s_axi_wready;
    assign wr_go   = (aw_have_reg | aw_now) & (w_have_reg | w_now)
                     & ~s_axi_bvalid;
    assign wr_addr = aw_have_reg ? aw_addr_reg : s_axi_awaddr;

    // byte-lane merge of write data
    reg [31:0] wd;
    reg [31:0] be;
    always @* begin
        wd = w_have_reg ? w_data_reg : s_axi_wdata;
        be = w_have_reg ? {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                           {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}}
                        : {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                           {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    end

    // decoded write strobes
    wire wr_mlo;
    wire wr_mhi;
    wire wr_sel;
    wire wr_clr;
    wire wr_cfg;
    wire wr_ok;
    assign wr_mlo = wr_go & (wr_addr == `GPIU_OFS_MASK1_LO
                          || wr_addr == `GPIU_OFS_MASK2_LO);
    assign wr_mhi = wr_go & (wr_addr == `GPIU_OFS_MASK1_HI
                          || wr_addr == `GPIU_OFS_MASK2_HI);
    assign wr_sel = wr_go & (wr_addr == `GPIU_OFS_MSEL);
    assign wr_clr = wr_go & (wr_addr == `GPIU_OFS_CLEAR);
    assign wr_cfg = wr_go & (wr_addr == `GPIU_OFS_PACFG);
    assign wr_ok  = wr_mlo | wr_mhi | wr_sel | wr_clr | wr_cfg;

    // selector gates which mask words a mask write lands in
    wire hit_first;
    wire hit_second;
    assign hit_first  = interrupt_mask_target_reg == `GPIU_SEL_FIRST
                     || interrupt_mask_target_reg == `GPIU_SEL_BOTH;
    assign hit_second = interrupt_mask_target_reg == `GPIU_SEL_SECOND
                     || interrupt_mask_target_reg == `GPIU_SEL_BOTH;

    // axi write handshake and register writes
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `GPIU_RESP_OK;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= `GPIU_ZERO32;
            w_strb_reg    <= 4'h0;
            first_pin_mask_word_reg   <= `GPIU_MASK_RST;
            second_pin_mask_word_reg  <= `GPIU_MASK_RST;
            interrupt_mask_target_reg <= `GPIU_SEL_BOTH;
            pa_en_reg     <= 1'b0;
            pa_sticky_reg <= 1'b0;
        end else begin
            if (aw_now && !wr_go) begin
                aw_have_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_now && !wr_go) begin
                w_have_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_reg   <= 1'b0;
                w_have_reg    <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= wr_ok ? `GPIU_RESP_OK : `GPIU_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (wr_mlo && hit_first) begin
                first_pin_mask_word_reg[31:0] <=
                    (first_pin_mask_word_reg[31:0] & ~be) | (wd & be);
            end
            if (wr_mhi && hit_first) begin
                first_pin_mask_word_reg[63:32] <=
                    (first_pin_mask_word_reg[63:32] & ~be) | (wd & be);
            end
            if (wr_mlo && hit_second) begin
                second_pin_mask_word_reg[31:0] <=
                    (second_pin_mask_word_reg[31:0] & ~be) | (wd & be);
            end
            if (wr_mhi && hit_second) begin
                second_pin_mask_word_reg[63:32] <=
                    (second_pin_mask_word_reg[63:32] & ~be) | (wd & be);
            end
            if (wr_sel && be[0]) begin
                interrupt_mask_target_reg <= wd[1:0];
            end
            if (wr_cfg && be[0]) begin
                pa_en_reg     <= wd[`GPIU_PA_EN_BIT];
                pa_sticky_reg <= wd[`GPIU_PA_STICKY_BIT];
            end
        end
    end

    // sticky status; new events win over a same-cycle clear
    wire clr_all;
    assign clr_all = wr_clr & be[0] & wd[0];
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_reg <= 64'h0000_0000_0000_0000;
        end else if (clr_all) begin
            status_reg <= live;
        end else begin
            status_reg <= status_reg | live;
        end
    end

    // interrupt pins and attenuation ramp
    wire pa_any;
    wire ramp_clr;
    assign pa_any   = |pa_sync;
    assign ramp_clr = wr_cfg & be[0] & wd[`GPIU_PA_CLR_BIT];
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_irq_pin_o  <= 1'b0;
            second_irq_pin_o <= 1'b0;
            ramp_hold_reg    <= 1'b0;
            tx_atten_ramp_o  <= 1'b0;
            wdog_limit_reg   <= `GPIU_WDOG_RST;
        end else begin
            first_irq_pin_o  <= |(live & ~first_pin_mask_word_reg);
            second_irq_pin_o <= |(live & ~second_pin_mask_word_reg);
            if (pa_en_reg && pa_any) begin
                ramp_hold_reg <= 1'b1;
            end else if (ramp_clr || !pa_en_reg) begin
                ramp_hold_reg <= 1'b0;
            end
            tx_atten_ramp_o <= pa_en_reg & (pa_any |
                               (pa_sticky_reg & ramp_hold_reg));
            wdog_limit_reg  <= wdog_limit_reg;
        end
    end

    // axi read channel
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `GPIU_ZERO32;
            s_axi_rresp   <= `GPIU_RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `GPIU_RESP_OK;
            if (s_axi_araddr == `GPIU_OFS_STAT_LO) begin
                s_axi_rdata <= status_reg[31:0];
            end else if (s_axi_araddr == `GPIU_OFS_STAT_HI) begin
                s_axi_rdata <= status_reg[63:32];
            end else if (s_axi_araddr == `GPIU_OFS_MASK1_LO) begin
                s_axi_rdata <= first_pin_mask_word_reg[31:0];
            end else if (s_axi_araddr == `GPIU_OFS_MASK1_HI) begin
                s_axi_rdata <= first_pin_mask_word_reg[63:32];
            end else if (s_axi_araddr == `GPIU_OFS_MASK2_LO) begin
                s_axi_rdata <= second_pin_mask_word_reg[31:0];
            end else if (s_axi_araddr == `GPIU_OFS_MASK2_HI) begin
                s_axi_rdata <= second_pin_mask_word_reg[63:32];
            end else if (s_axi_araddr == `GPIU_OFS_MSEL) begin
                s_axi_rdata <= {30'h0000_0000, interrupt_mask_target_reg};
            end else if (s_axi_araddr == `GPIU_OFS_CLEAR) begin
                s_axi_rdata <= `GPIU_ZERO32;
            end else if (s_axi_araddr == `GPIU_OFS_PACFG) begin
                s_axi_rdata <= {28'h000_0000, tx_atten_ramp_o, 1'b0,
                                pa_sticky_reg, pa_en_reg};
            end else if (s_axi_araddr == `GPIU_OFS_LIVE_LO) begin
                s_axi_rdata <= live[31:0];
            end else if (s_axi_araddr == `GPIU_OFS_LIVE_HI) begin
                s_axi_rdata <= live[63:32];
            end else begin
                s_axi_rdata <= `GPIU_ZERO32;
                s_axi_rresp <= `GPIU_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// ==== src/gpiu_defs.vh ====
// constants for the general purpose interrupt unit
`ifndef GPIU_DEFS_VH
`define GPIU_DEFS_VH

// register byte offsets
`define GPIU_OFS_STAT_LO   8'h00
`define GPIU_OFS_STAT_HI   8'h04
`define GPIU_OFS_MASK1_LO  8'h08
`define GPIU_OFS_MASK1_HI  8'h0c
`define GPIU_OFS_MASK2_LO  8'h10
`define GPIU_OFS_MASK2_HI  8'h14
`define GPIU_OFS_MSEL      8'h18
`define GPIU_OFS_CLEAR     8'h1c
`define GPIU_OFS_PACFG     8'h20
`define GPIU_OFS_LIVE_LO   8'h24
`define GPIU_OFS_LIVE_HI   8'h28

// interrupt_mask_target selector codes
`define GPIU_SEL_FIRST     2'h0
`define GPIU_SEL_SECOND    2'h1
`define GPIU_SEL_BOTH      2'h2

// source bit positions in the 64 bit word
`define GPIU_BIT_FORCED    6'h00
`define GPIU_BIT_WDOG      6'h01
`define GPIU_BIT_SLEW      6'h02
`define GPIU_BIT_SYSERR    6'h03
`define GPIU_BIT_STRM_LO   6'h04
`define GPIU_BIT_ECC       6'h08
`define GPIU_BIT_PA_LO     6'h09
`define GPIU_BIT_OTHER_LO  6'h0b

// field widths
`define GPIU_NSTRM         4
`define GPIU_NPA           2
`define GPIU_NOTHER        53
`define GPIU_NTX           4
`define GPIU_WDOG_W        16

// reset values
`define GPIU_MASK_RST      64'hffff_ffff_ffff_ffff
`define GPIU_WDOG_RST      16'hffff
`define GPIU_ZERO32        32'h0000_0000
`define GPIU_RESP_OK       2'h0
`define GPIU_RESP_SLVERR   2'h2

// pacfg fields
`define GPIU_PA_EN_BIT     0
`define GPIU_PA_STICKY_BIT 1
`define GPIU_PA_CLR_BIT    2

`endif

// ==== src/gpiu_sync.v ====
// three flop synchroniser with agreement filter
`timescale 1ns/10ps
module gpiu_sync (
    input  wire mclk_i,   // clock
    input  wire rst_n_i,  // async reset, low
    input  wire d_i,      // async input
    output reg  q_o       // filtered level
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // stage chain; change counts when stage two and three agree
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                q_o <= s3_reg;
            end
        end
    end
endmodule

// ==== src/gpiu_wdog.v ====
// watchdog counter of the embedded processor
`timescale 1ns/10ps
`include "gpiu_defs.vh"
module gpiu_wdog (
    input  wire                    mclk_i,    // clock
    input  wire                    rst_n_i,   // async reset, low
    input  wire                    kick_i,    // restart pulse
    input  wire [`GPIU_WDOG_W-1:0] limit_i,   // timeout value
    output reg                     expire_o   // level once timed out
);
    reg [`GPIU_WDOG_W-1:0] cnt_reg;

    // counts up, restarts on kick, holds expiry until kicked
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= {`GPIU_WDOG_W{1'b0}};
            expire_o <= 1'b0;
        end else if (kick_i) begin
            cnt_reg  <= {`GPIU_WDOG_W{1'b0}};
            expire_o <= 1'b0;
        end else if (cnt_reg >= limit_i) begin
            expire_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + {{(`GPIU_WDOG_W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// ==== dv/gpiu_props.sv ====
// checker of pin, ramp and bus timing at the unit ports
`timescale 1ns/10ps
module gpiu_props (
    input wire        mclk_i,           // clock
    input wire        rst_n_i,          // reset, low
    input wire        s_axi_awvalid,    // aw valid
    input wire        s_axi_awready,    // aw ready
    input wire        s_axi_wvalid,     // w valid
    input wire        s_axi_wready,     // w ready
    input wire [1:0]  s_axi_bresp,      // b code
    input wire        s_axi_bvalid,     // b valid
    input wire        s_axi_bready,     // b ready
    input wire        s_axi_arvalid,    // ar valid
    input wire        s_axi_arready,    // ar ready
    input wire [31:0] s_axi_rdata,      // r data
    input wire        s_axi_rvalid,     // r valid
    input wire        s_axi_rready,     // r ready
    input wire        fw_fatal_i,       // source
    input wire        wdog_kick_i,      // restart
    input wire [3:0]  slew_err_i,       // source
    input wire        cal_err_i,        // source
    input wire        sys_err_i,        // source
    input wire [3:0]  strm_err_i,       // source
    input wire        ecc_err_i,        // source
    input wire [1:0]  pa_event_i,       // source
    input wire [52:0] other_src_i,      // source
    input wire        first_irq_pin_o,  // pin
    input wire        second_irq_pin_o, // pin
    input wire        tx_atten_ramp_o   // ramp
);
    logic        any_src;
    logic [3:0]  since_src_reg;
    logic [3:0]  since_pa_reg;
    logic [16:0] since_kick_reg;

    // any source input active this cycle
    assign any_src = fw_fatal_i | (|slew_err_i) | cal_err_i | sys_err_i
                   | (|strm_err_i) | ecc_err_i | (|pa_event_i)
                   | (|other_src_i);

    // saturating ages of last source, pa event and restart
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since_src_reg  <= 4'hf;
            since_pa_reg   <= 4'hf;
            since_kick_reg <= 17'h00000;
        end else begin
            if (any_src) since_src_reg <= 4'h0;
            else if (since_src_reg != 4'hf) since_src_reg <= since_src_reg + 4'h1;
            if (|pa_event_i) since_pa_reg <= 4'h0;
            else if (since_pa_reg != 4'hf) since_pa_reg <= since_pa_reg + 4'h1;
            if (wdog_kick_i) since_kick_reg <= 17'h00000;
            else if (since_kick_reg != 17'h1ffff)
                since_kick_reg <= since_kick_reg + 17'h00001;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_pin_one_cause: assert property (
        $rose(first_irq_pin_o) |-> since_src_reg <= 4'h7
            || since_kick_reg > 17'h0ea60)
        else $error("first pin rose with no source");
    chk_pin_two_cause: assert property (
        $rose(second_irq_pin_o) |-> since_src_reg <= 4'h7
            || since_kick_reg > 17'h0ea60)
        else $error("second pin rose with no source");
    chk_pins_quiet: assert property (
        since_src_reg == 4'hf && since_kick_reg > 17'h00004
            && since_kick_reg < 17'h0ea60
            |-> !first_irq_pin_o && !second_irq_pin_o)
        else $error("pin held with no live source");
    chk_ramp_cause: assert property (
        $rose(tx_atten_ramp_o) |-> since_pa_reg <= 4'h7)
        else $error("ramp rose with no pa event");
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> s_axi_bvalid)
        else $error("no write response after capture");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read response after capture");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_write_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");

    cover property ($rose(first_irq_pin_o));
    cover property ($rose(second_irq_pin_o));
    cover property ($rose(tx_atten_ramp_o));
endmodule

bind gpiu_top gpiu_props u_props (.*);

// ==== dv/gpiu_bbp.sv ====
// baseband side model counting rising edges on both pins
`timescale 1ns/10ps
module gpiu_bbp (
    input  wire        mclk_i,  // clock
    input  wire        rst_n_i, // reset, low
    input  wire        pin1_i,  // first pin
    input  wire        pin2_i,  // second pin
    output logic [7:0] rise1_o, // edges on first pin
    output logic [7:0] rise2_o  // edges on second pin
);
    logic last1_reg;
    logic last2_reg;

    // interrupts are noticed on rising edges only
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last1_reg <= 1'b0;
            last2_reg <= 1'b0;
            rise1_o   <= 8'h00;
            rise2_o   <= 8'h00;
        end else begin
            last1_reg <= pin1_i;
            last2_reg <= pin2_i;
            if (pin1_i && !last1_reg) rise1_o <= rise1_o + 8'h01;
            if (pin2_i && !last2_reg) rise2_o <= rise2_o + 8'h01;
        end
    end
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the interrupt unit
`timescale 1ns/10ps
module tb_top;
    logic        mclk_i, rst_n_i, fw_fatal_i, wdog_kick_i, cal_err_i;
    logic        sys_err_i, ecc_err_i, first_irq_pin_o, second_irq_pin_o;
    logic        tx_atten_ramp_o, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, rise1, rise2;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb, slew_err_i, strm_err_i;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pa_event_i, resp;
    logic [52:0] other_src_i;
    int          fails, compares, cyc;

    // unit under test and baseband model
    gpiu_top u_dut (.*);
    gpiu_bbp u_bbp (.mclk_i, .rst_n_i, .pin1_i(first_irq_pin_o),
        .pin2_i(second_irq_pin_o), .rise1_o(rise1), .rise2_o(rise2));

    // 125 mhz clock
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    // hang guard
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            fails = fails + 1;
            print_verdict();
        end
    end

    task print_verdict();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [63:0] seen, input logic [63:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task nap(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // axi4-lite write, response waited for
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // axi4-lite read with a slow rready
    task rd(input logic [7:0] a);
        @(posedge mclk_i);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rdat, e);
    endtask

    // drive one source input by index
    task src(input int i, input logic v, input int n);
        @(posedge mclk_i);
        case (i)
            0:       fw_fatal_i <= v;
            1, 2, 3, 4: slew_err_i[i-1] <= v;
            5:       cal_err_i <= v;
            6:       sys_err_i <= v;
            11:      ecc_err_i <= v;
            12, 13:  pa_event_i[i-12] <= v;
            14:      other_src_i[52] <= v;
            15:      wdog_kick_i <= v;
            default: strm_err_i[i-7] <= v;
        endcase
        nap(n);
    endtask

    function automatic int ebit(input int i);
        if (i == 0) return 0;
        if (i < 5) return 2;
        if (i < 7) return 3;
        if (i == 11) return 8;
        return i - 3;
    endfunction

    task t_reset();
        chk(first_irq_pin_o | second_irq_pin_o, 1'b0);
        rchk(8'h00, 32'h0);
        for (int a = 8; a < 24; a += 4) begin
            rchk(a[7:0], 32'hffffffff);
        end
        rchk(8'h18, 32'h2);
        rd(8'h3c);
        chk({rdat, resp}, 34'h2);
        wr(8'h3c, 32'h1);
        chk(resp, 2'h2);
    endtask

    task t_sources();
        for (int i = 0; i < 14; i++) begin
            src(i, 1'b1, 10);
            chk(first_irq_pin_o | second_irq_pin_o, 1'b0);
            src(i, 1'b0, 10);
            rchk(8'h00, 32'h1 << ebit(i));
            wr(8'h1c, 32'h1);
            rchk(8'h00, 32'h0);
        end
    endtask

    task t_masks();
        wr(8'h18, 32'h0);
        wr(8'h10, 32'hfffffffe);
        rchk(8'h08, 32'hfffffffe);
        rchk(8'h10, 32'hffffffff);
        wr(8'h18, 32'h1);
        wr(8'h08, 32'hfffffffd);
        rchk(8'h08, 32'hfffffffe);
        rchk(8'h10, 32'hfffffffd);
        wr(8'h18, 32'h2);
        wr(8'h0c, 32'h7fffffff);
        rchk(8'h0c, 32'h7fffffff);
        rchk(8'h14, 32'h7fffffff);
        src(0, 1'b1, 4);
        chk({first_irq_pin_o, second_irq_pin_o}, 2'h2);
        src(0, 1'b0, 4);
        chk(first_irq_pin_o, 1'b0);
        src(14, 1'b1, 10);
        chk({first_irq_pin_o, second_irq_pin_o}, 2'h3);
        src(14, 1'b0, 10);
        chk({first_irq_pin_o, second_irq_pin_o}, 2'h0);
        chk(rise1, 8'h02);
        rchk(8'h00, 32'h1);
        rchk(8'h04, 32'h80000000);
        wr(8'h1c, 32'h1);
    endtask

    task t_ramp();
        src(12, 1'b1, 10);
        chk(tx_atten_ramp_o, 1'b0);
        src(12, 1'b0, 10);
        wr(8'h20, 32'h1);
        src(13, 1'b1, 10);
        chk(tx_atten_ramp_o, 1'b1);
        src(13, 1'b0, 10);
        chk(tx_atten_ramp_o, 1'b0);
        wr(8'h20, 32'h7);
        src(12, 1'b1, 10);
        src(12, 1'b0, 10);
        chk(tx_atten_ramp_o, 1'b1);
        wr(8'h20, 32'h7);
        nap(2);
        chk(tx_atten_ramp_o, 1'b0);
        wr(8'h20, 32'h0);
        wr(8'h1c, 32'h1);
    endtask

    task t_wdog();
        logic [7:0] b;
        b = rise2;
        src(15, 1'b1, 0);
        src(15, 1'b0, 65000);
        chk(second_irq_pin_o, 1'b0);
        nap(600);
        chk(second_irq_pin_o, 1'b1);
        chk(rise2, b + 8'h01);
        // handler masks the second pin's low word, reads status, restores mask
        wr(8'h18, 32'h1);
        wr(8'h10, 32'hffffffff);
        nap(3);
        chk(second_irq_pin_o, 1'b0);
        rchk(8'h00, 32'h2);
        wr(8'h10, 32'hfffffffd);
        nap(3);
        chk(rise2, b + 8'h02);
        src(15, 1'b1, 0);
        src(15, 1'b0, 4);
        chk(second_irq_pin_o, 1'b0);
    endtask

    // reset, then the scenarios in order
    initial begin
        fails = 0;
        compares = 0;
        cyc = 0;
        rst_n_i = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        s_axi_rready = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        {fw_fatal_i, wdog_kick_i, cal_err_i, sys_err_i, ecc_err_i} = 5'h00;
        {slew_err_i, strm_err_i, pa_event_i} = 10'h000;
        other_src_i = 53'h0;
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_sources();
        t_masks();
        t_ramp();
        t_wdog();
        print_verdict();
    end
endmodule
